/* rtl/mdt_map.svh */
// Operation
// - invert line at every bit start, again at mid-bit only for a one
// - each half bit lasts 2176 cycles of a 16 MHz instruction clock
// - bytes leave the matrix column by column, top to bottom
// - waveform is one toggled bit of the output port latch
// - pause nominally 4 ms between consecutive blocks
// - matrix for the next block is filled only after the gap has run out
// - sample attached-device status in every gap before the next block
// - one pass covers 32 consecutive blocks of 256 payload bytes
// - wrap after last block, repeat, stop only on detach
// - bits of each byte go out least significant first
// - matrix is 24 rows by 16 columns, 11 data then 5 check
// - block opens with marker 8B AD F0 0D, address and context, little endian
// - last check column is XOR of the preceding fifteen columns
`ifndef MDT_MAP_SVH
`define MDT_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define MDT_HALF_BIT_INSTR 2176
`define MDT_INSTR_KHZ      16000
`define MDT_CLK_KHZ        25000
`define MDT_HALF_BIT_CYC   ((`MDT_HALF_BIT_INSTR * `MDT_CLK_KHZ) / `MDT_INSTR_KHZ)
`define MDT_GAP_US         4000
`define MDT_GAP_CYC        ((`MDT_GAP_US * `MDT_CLK_KHZ) / 1000)
// ----------------------------------------
// layout
// ----------------------------------------
`define MDT_ROWS           24
`define MDT_COLS           16
`define MDT_DATA_COLS      11
`define MDT_META_BYTES     8
`define MDT_BLOCK_BYTES    256
`define MDT_BLOCKS         32
`define MDT_BASE_ADDR      16'h0800
`define MDT_MARK0          8'h8B
`define MDT_MARK1          8'hAD
`define MDT_MARK2          8'hF0
`define MDT_MARK3          8'h0D
`define MDT_IDLE_LEVEL     1'b0
`endif

/* rtl/mdt_pkg.sv */
package mdt_pkg;
	typedef enum logic [2:0] {
		MDT_IDLE,
		MDT_FILL,
		MDT_CHECK,
		MDT_SEND,
		MDT_GAP
	} mdt_state_type;
endpackage : mdt_pkg

/* rtl/mdt_dump_tx.sv */
`timescale 1ns/100ps
`include "mdt_map.svh"
module mdt_dump_tx #(
	parameter int unsigned GAP_CYC      = `MDT_GAP_CYC,
	parameter int unsigned HALF_BIT_CYC = `MDT_HALF_BIT_CYC,
	parameter int unsigned BLOCKS       = `MDT_BLOCKS
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	input  wire logic        CE,
	input  wire logic        DUMP_REQ,
	input  wire logic        DEV_ATTACHED,
	input  wire logic [15:0] CONTEXT_WORD,
	input  wire logic [7:0]  MEM_RDATA,
	output logic             MEM_RD,
	output logic      [15:0] MEM_ADDR,
	output logic             LINE_OUT,
	output logic             BUSY
);
	localparam int NCELL = `MDT_ROWS * `MDT_COLS;

	// ----------------------------------------
	// state
	// ----------------------------------------
	mdt_pkg::mdt_state_type state_q, state_d;
	logic [7:0]  mat_q [0:NCELL-1];
	logic [7:0]  mat_d [0:NCELL-1];
	logic [4:0]  blk_q, blk_d;
	logic [8:0]  k_q, k_d;
	logic [4:0]  row_q, row_d;
	logic [3:0]  col_q, col_d;
	logic [2:0]  bit_q, bit_d;
	logic        half_q, half_d;
	logic        ph_q, ph_d;
	logic [11:0] tmr_q, tmr_d;
	logic [31:0] gap_q, gap_d;
	logic        latch_q, latch_d;
	logic        rd_q, rd_d;
	logic [15:0] addr_q, addr_d;
	logic        busy_q, busy_d;
	logic [2:0]  att_s_q, att_s_d;
	logic [2:0]  req_s_q, req_s_d;
	logic        att_q, att_d;
	logic        req_q, req_d;

	logic [15:0] blk_addr;
	logic [7:0]  x [0:10];
	logic [7:0]  y0, y1, y2, y3, z;
	logic [7:0]  cur_byte;
	logic [7:0]  meta;

	assign MEM_RD   = rd_q;
	assign MEM_ADDR = addr_q;
	assign LINE_OUT = latch_q;
	assign BUSY     = busy_q;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		for (int i = 0; i < NCELL; i++) begin
			mat_d[i] = mat_q[i];
		end
		blk_d   = blk_q;
		k_d     = k_q;
		row_d   = row_q;
		col_d   = col_q;
		bit_d   = bit_q;
		half_d  = half_q;
		ph_d    = ph_q;
		tmr_d   = tmr_q;
		gap_d   = gap_q;
		latch_d = latch_q;
		rd_d    = 1'b0;
		addr_d  = addr_q;
		busy_d  = (state_q != mdt_pkg::MDT_IDLE);
		// only stages two and three are compared; stage one feeds stage two alone
		att_s_d = {att_s_q[1:0], DEV_ATTACHED};
		req_s_d = {req_s_q[1:0], DUMP_REQ};
		att_d   = (att_s_q[1] == att_s_q[2]) ? att_s_q[2] : att_q;
		req_d   = (req_s_q[1] == req_s_q[2]) ? req_s_q[2] : req_q;

		blk_addr = `MDT_BASE_ADDR + {3'h0, blk_q, 8'h00};
		unique case (k_q[2:0])
			3'h0:    meta = `MDT_MARK0;
			3'h1:    meta = `MDT_MARK1;
			3'h2:    meta = `MDT_MARK2;
			3'h3:    meta = `MDT_MARK3;
			3'h4:    meta = blk_addr[7:0];
			3'h5:    meta = blk_addr[15:8];
			3'h6:    meta = CONTEXT_WORD[7:0];
			default: meta = CONTEXT_WORD[15:8];
		endcase

		for (int j = 0; j < 11; j++) begin
			x[j] = mat_q[{row_q, 4'(j)}];
		end
		y0 = x[0] ^ x[1] ^ x[3] ^ x[4] ^ x[6] ^ x[8] ^ x[10];
		y1 = x[0] ^ x[2] ^ x[3] ^ x[5] ^ x[6] ^ x[9] ^ x[10];
		y2 = x[1] ^ x[2] ^ x[3] ^ x[7] ^ x[8] ^ x[9] ^ x[10];
		y3 = x[4] ^ x[5] ^ x[6] ^ x[7] ^ x[8] ^ x[9] ^ x[10];
		// full sum kept rather than the reduced form: easier to check by eye
		z  = y0 ^ y1 ^ y2 ^ y3;
		for (int j = 0; j < 11; j++) begin
			z = z ^ x[j];
		end

		cur_byte = mat_q[{row_q, col_q}];

		unique case (state_q)
			mdt_pkg::MDT_IDLE: begin
				latch_d = `MDT_IDLE_LEVEL;
				if (req_q && att_q) begin
					state_d = mdt_pkg::MDT_FILL;
					blk_d   = '0;
					k_d     = '0;
					row_d   = '0;
					col_d   = '0;
					ph_d    = 1'b0;
				end
			end
			mdt_pkg::MDT_FILL: begin
				if (k_q < 9'(`MDT_META_BYTES) || ph_q) begin
					mat_d[{row_q, col_q}] = (k_q < 9'(`MDT_META_BYTES)) ? meta : MEM_RDATA;
					ph_d = 1'b0;
					if (k_q == 9'(`MDT_META_BYTES + `MDT_BLOCK_BYTES - 1)) begin
						state_d = mdt_pkg::MDT_CHECK;
						row_d   = '0;
					end else begin
						k_d = k_q + 9'h001;
						if (col_q == 4'(`MDT_DATA_COLS - 1)) begin
							col_d = '0;
							row_d = row_q + 5'h01;
						end else begin
							col_d = col_q + 4'h1;
						end
					end
				end else begin
					rd_d   = 1'b1;
					addr_d = blk_addr + 16'(k_q - 9'(`MDT_META_BYTES));
					ph_d   = 1'b1;
				end
			end
			mdt_pkg::MDT_CHECK: begin
				mat_d[{row_q, 4'hb}] = y0;
				mat_d[{row_q, 4'hc}] = y1;
				mat_d[{row_q, 4'hd}] = y2;
				mat_d[{row_q, 4'he}] = y3;
				mat_d[{row_q, 4'hf}] = z;
				if (row_q == 5'(`MDT_ROWS - 1)) begin
					state_d = mdt_pkg::MDT_SEND;
					row_d   = '0;
					col_d   = '0;
					bit_d   = '0;
					half_d  = 1'b0;
					latch_d = ~latch_q;
					tmr_d   = 12'(HALF_BIT_CYC - 1);
				end else begin
					row_d = row_q + 5'h01;
				end
			end
			mdt_pkg::MDT_SEND: begin
				if (tmr_q != 12'h000) begin
					tmr_d = tmr_q - 12'h001;
				end else if (!half_q) begin
					half_d = 1'b1;
					tmr_d  = 12'(HALF_BIT_CYC - 1);
					if (cur_byte[bit_q]) begin
						latch_d = ~latch_q;
					end
				end else if (bit_q == 3'h7 && row_q == 5'(`MDT_ROWS - 1)
					&& col_q == 4'(`MDT_COLS - 1)) begin
					state_d = mdt_pkg::MDT_GAP;
					gap_d   = GAP_CYC - 1;
				end else begin
					half_d  = 1'b0;
					tmr_d   = 12'(HALF_BIT_CYC - 1);
					latch_d = ~latch_q;
					bit_d   = bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						if (row_q == 5'(`MDT_ROWS - 1)) begin
							row_d = '0;
							col_d = col_q + 4'h1;
						end else begin
							row_d = row_q + 5'h01;
						end
					end
				end
			end
			mdt_pkg::MDT_GAP: begin
				if (gap_q != 32'h0000_0000) begin
					gap_d = gap_q - 32'h0000_0001;
				end else if (!att_q) begin
					state_d = mdt_pkg::MDT_IDLE;
				end else begin
					state_d = mdt_pkg::MDT_FILL;
					blk_d   = (blk_q == 5'(BLOCKS - 1)) ? 5'h00 : blk_q + 5'h01;
					k_d     = '0;
					row_d   = '0;
					col_d   = '0;
					ph_d    = 1'b0;
				end
			end
			// three spare state codes: fall back to idle rather than hang
			default: state_d = mdt_pkg::MDT_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= mdt_pkg::MDT_IDLE;
			for (int i = 0; i < NCELL; i++) begin
				mat_q[i] <= '0;
			end
			blk_q   <= '0;
			k_q     <= '0;
			row_q   <= '0;
			col_q   <= '0;
			bit_q   <= '0;
			half_q  <= 1'b0;
			ph_q    <= 1'b0;
			tmr_q   <= '0;
			gap_q   <= '0;
			latch_q <= `MDT_IDLE_LEVEL;
			rd_q    <= 1'b0;
			addr_q  <= '0;
			busy_q  <= 1'b0;
			att_s_q <= '0;
			req_s_q <= '0;
			att_q   <= 1'b0;
			req_q   <= 1'b0;
		end else if (CE) begin
			state_q <= state_d;
			for (int i = 0; i < NCELL; i++) begin
				mat_q[i] <= mat_d[i];
			end
			blk_q   <= blk_d;
			k_q     <= k_d;
			row_q   <= row_d;
			col_q   <= col_d;
			bit_q   <= bit_d;
			half_q  <= half_d;
			ph_q    <= ph_d;
			tmr_q   <= tmr_d;
			gap_q   <= gap_d;
			latch_q <= latch_d;
			rd_q    <= rd_d;
			addr_q  <= addr_d;
			busy_q  <= busy_d;
			att_s_q <= att_s_d;
			req_s_q <= req_s_d;
			att_q   <= att_d;
			req_q   <= req_d;
		end
	end
endmodule : mdt_dump_tx

/* sim/mdt_sva.sv */
`timescale 1ns/100ps
module mdt_sva #(
	parameter int unsigned BLOCKS = 32
) (
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic        MEM_RD,
	input wire logic [15:0] MEM_ADDR,
	input wire logic        LINE_OUT,
	input wire logic        BUSY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// bench runs four cycles per half bit
	sequence s_hold;
		$stable(LINE_OUT)[*3];
	endsequence
	a_half_hold: assert property ($changed(LINE_OUT) |=> s_hold) else $error("half bit too short");
	a_rd_pulse: assert property (MEM_RD |=> !MEM_RD) else $error("read strobe too long");
	a_fill_quiet: assert property (MEM_RD |-> $stable(LINE_OUT)) else $error("line moved in fill");
	a_addr_step: assert property (MEM_RD ##2 MEM_RD |-> MEM_ADDR == $past(MEM_ADDR, 2) + 16'h0001)
		else $error("address not ascending");
	a_addr_range: assert property (MEM_RD |-> MEM_ADDR >= 16'h0800 && MEM_ADDR < 16'h0800 + BLOCKS * 256)
		else $error("address outside dump");
	a_blk_align: assert property (MEM_RD && !$past(MEM_RD, 2) |-> MEM_ADDR[7:0] == 8'h00)
		else $error("block not aligned");
	a_start_fill: assert property ($rose(BUSY) |-> ##[1:20] MEM_RD) else $error("no fill after start");
	a_idle_low: assert property (!BUSY ##1 !BUSY |-> !LINE_OUT) else $error("line not idle");
	a_idle_no_rd: assert property (!BUSY |-> !MEM_RD) else $error("read while idle");
endmodule : mdt_sva
bind mdt_dump_tx mdt_sva #(.BLOCKS(BLOCKS)) sva_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .MEM_RD(MEM_RD),
	.MEM_ADDR(MEM_ADDR), .LINE_OUT(LINE_OUT), .BUSY(BUSY));

/* sim/mdt_rec.sv */
`timescale 1ns/100ps
module mdt_rec #(
	parameter int unsigned HALF = 4
) (
	input wire logic  clk,
	input wire logic  rst_b,
	input wire logic  line,
	output logic      byte_v,
	output logic [7:0] byte_q
);
	logic        line_q, half_q, frm_q, bit_v, bit_d;
	logic [15:0] cnt_q;
	logic [2:0]  nb_q;
	logic [7:0]  sh_q;
	// silence ends a frame, so the last bit of a block still lands
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{line_q, half_q, frm_q, byte_v, cnt_q, nb_q, sh_q, byte_q} <= '0;
		end else begin
			line_q <= line;
			byte_v <= 1'b0;
			bit_v = 1'b0;
			bit_d = 1'b0;
			if (line != line_q) begin
				cnt_q <= 16'h0001;
				frm_q <= 1'b1;
				if (!frm_q) begin
					half_q <= 1'b0;
					nb_q <= 3'h0;
				end else if (cnt_q > HALF * 3 / 2) begin
					bit_v = 1'b1;
				end else if (half_q) begin
					bit_v = 1'b1;
					bit_d = 1'b1;
					half_q <= 1'b0;
				end else begin
					half_q <= 1'b1;
				end
			end else begin
				cnt_q <= cnt_q + 16'h0001;
				if (frm_q && cnt_q == HALF * 5 / 2) begin
					bit_v = 1'b1;
					bit_d = half_q;
					frm_q <= 1'b0;
					half_q <= 1'b0;
				end
			end
			if (bit_v) begin
				sh_q <= {bit_d, sh_q[7:1]};
				nb_q <= nb_q + 3'h1;
				byte_v <= (nb_q == 3'h7);
				byte_q <= {bit_d, sh_q[7:1]};
			end
		end
	end
endmodule : mdt_rec

/* sim/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin err_total++; $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_top;
	logic        clk = 0, rst_b = 0, req = 0, att = 0, ce = 1;
	logic [7:0]  rdata = 8'h00;
	logic [15:0] ctx = 16'hc3a5;
	wire logic   mem_rd, line_out, busy, byte_v;
	wire logic [15:0] mem_addr;
	wire logic [7:0]  byte_q;
	int          err_total = 0, n_tests = 0;
	always #20 clk = ~clk;
	mdt_dump_tx #(.GAP_CYC(50), .HALF_BIT_CYC(4), .BLOCKS(2)) dut_u (.CLK_SYS(clk), .RST_B(rst_b), .CE(ce),
		.DUMP_REQ(req), .DEV_ATTACHED(att), .CONTEXT_WORD(ctx), .MEM_RDATA(rdata), .MEM_RD(mem_rd),
		.MEM_ADDR(mem_addr), .LINE_OUT(line_out), .BUSY(busy));
	mdt_rec #(.HALF(4)) rec_u (.clk(clk), .rst_b(rst_b), .line(line_out), .byte_v(byte_v), .byte_q(byte_q));
	// ----------------------------------------
	// memory and expectations
	// ----------------------------------------
	always @(negedge clk) if (mem_rd) rdata <= mem_addr[7:0] ^ 8'h5a;
	function automatic logic [7:0] raw(int blk, int k);
		logic [7:0] m [8];
		m = '{8'h8b, 8'had, 8'hf0, 8'h0d, 8'h00, 8'h08 + 8'(blk), ctx[7:0], ctx[15:8]};
		return (k < 8) ? m[k] : 8'(k - 8) ^ 8'h5a;
	endfunction : raw
	function automatic logic [7:0] exp_b(int blk, int i);
		logic [7:0] c [16];
		for (int j = 0; j < 11; j++) c[j] = raw(blk, 11 * (i % 24) + j);
		c[11] = c[0] ^ c[1] ^ c[3] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
		c[12] = c[0] ^ c[2] ^ c[3] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
		c[13] = c[1] ^ c[2] ^ c[3] ^ c[7] ^ c[8] ^ c[9] ^ c[10];
		c[14] = c[4] ^ c[5] ^ c[6] ^ c[7] ^ c[8] ^ c[9] ^ c[10];
		c[15] = 8'h00;
		for (int j = 0; j < 15; j++) c[15] ^= c[j];
		return c[i / 24];
	endfunction : exp_b
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_idle;
		att = 1'b1;
		repeat (12) @(negedge clk);
		`CHK("idle line", 1'b0, line_out)
		`CHK("idle busy", 1'b0, busy)
		// clock enable low: a request must not even reach the synchroniser
		ce = 1'b0;
		req = 1'b1;
		repeat (12) @(negedge clk);
		`CHK("frozen busy", 1'b0, busy)
		`CHK("frozen line", 1'b0, line_out)
		ce = 1'b1;
	endtask : t_idle
	// drop ends the run: detach early in the block, stop seen after it
	task t_block(int blk, bit drop);
		for (int i = 0; i < 384; i++) begin
			@(negedge clk iff byte_v);
			`CHK("stream byte", exp_b(blk, i), byte_q)
			// address high byte sits in row 0, column 5: stream position 120
			if (i == 120) `CHK("block address", 8'h08 + 8'(blk), byte_q)
			if (drop && i == 0) {att, req} = 2'b00;
		end
	endtask : t_block
	task t_stop;
		for (int n = 0; n < 300 && busy !== 1'b0; n++) @(negedge clk);
		`CHK("stop on detach", 1'b0, busy)
		`CHK("stop line idle", 1'b0, line_out)
	endtask : t_stop
	// silent span between blocks: gap plus refill, loose bounds
	task t_pause;
		int   n;
		logic lvl;
		lvl = line_out;
		n = 0;
		while (line_out === lvl && n < 2000) begin
			@(negedge clk);
			n++;
		end
		`CHK("block pause", 1'b1, (n >= 50 && n <= 700))
	endtask : t_pause
	task close_out;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		t_idle();
		req = 1'b1;
		t_block(0, 1'b0);
		t_pause();
		t_block(1, 1'b0);
		t_block(0, 1'b1);
		t_stop();
		close_out();
	end
	initial begin
		#(40 * 95000);
		err_total++;
		close_out();
	end
endmodule : tb_top
